//--- pio_pkg.sv
// constants shared by the programmable pin port: register word indexes, reset values, pin modes
// assumes a 32-bit axi4-lite register bus and a single 100 mhz clock
// How it works
// - each of 32 pins has own direction bit
// - direction bit n pairs with mode bit n
// - upper direction bit 15 is pin 31, downward
// - direction one means input, zero output/normal
// - upper direction resets to all ones
// - lower direction resets to FC0F pattern
// - output pins drive data bit, no inversion
// - input pins read pin level, no inversion
// - data bits map like mode and direction
// - data registers have no defined reset value
// - mode,direction: 00 normal,01 pull,10 out,11 in
// - port function disconnects normal pin function
// - mode registers reset to zero, msb pin 31
package pio_pkg;
   localparam int unsigned LANE_W = 2; // byte-lane bits below the word index
   localparam int unsigned IDX_W = 8; // register word index width
   localparam int unsigned ADDR_W = IDX_W + LANE_W; // byte address width seen by the slave
   localparam int unsigned HALF_W = 16; // width of each documented register
   localparam int unsigned PIN_N = 32; // number of port pins
   // word indexes; some sit on odd halves, so each register gets a whole word at four times its index
   localparam logic [IDX_W-1:0] OFS_MODE_LO = 8'h70; // pin_function_select_low
   localparam logic [IDX_W-1:0] OFS_DIR_LO = 8'h72; // pin_direction_low
   localparam logic [IDX_W-1:0] OFS_LVL_LO = 8'h74; // pin_level_low
   localparam logic [IDX_W-1:0] OFS_MODE_HI = 8'h76; // pin_function_select_high
   localparam logic [IDX_W-1:0] OFS_DIR_HI = 8'h78; // pin_direction_high
   localparam logic [IDX_W-1:0] OFS_LVL_HI = 8'h7A; // pin_level_high
   localparam logic [HALF_W-1:0] RST_MODE = 16'h0000; // both mode registers
   localparam logic [HALF_W-1:0] RST_DIR_LO = 16'hFC0F; // lower direction
   localparam logic [HALF_W-1:0] RST_DIR_HI = 16'hFFFF; // upper direction
   localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
   localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error for unmapped words
   // pin function as {mode, direction}
   typedef enum logic [1:0] {
      FN_NORMAL = 2'b00, // normal on-chip function
      FN_IN_PULL = 2'b01, // input with pull resistor
      FN_OUT = 2'b10, // port output
      FN_IN_NOPULL = 2'b11 // input without pull
   } pin_fn_t;
endpackage

//--- programmable_io_port.sv
// programmable 32-pin i/o port with axi4-lite register access
// assumes pins are asynchronous to aclk; pad wires are resolved outside from the enables
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module programmable_io_port (
   input wire logic aclk, // 100 mhz clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [pio_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [pio_pkg::ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [pio_pkg::PIN_N-1:0] pin_in, // pad input levels
   output logic [pio_pkg::PIN_N-1:0] pin_out, // pad output levels
   output logic [pio_pkg::PIN_N-1:0] pin_oe, // pad output enables, high while driving
   output logic [pio_pkg::PIN_N-1:0] pin_pull_en, // weak pull resistor enables
   input wire logic [pio_pkg::PIN_N-1:0] func_out, // normal function output per pin
   input wire logic [pio_pkg::PIN_N-1:0] func_oe, // normal function output enable per pin
   output logic [pio_pkg::PIN_N-1:0] func_in // pad level back to the normal function
);
   import pio_pkg::*;

   // pin configuration state, bit n of the 32-bit vector is pin n
   logic [PIN_N-1:0] mode_ff, nxt_mode; // function_select_bits
   logic [PIN_N-1:0] dir_ff, nxt_dir; // direction_bits
   logic [PIN_N-1:0] lvl_ff, nxt_lvl; // level_bits written by software
   // three-stage input synchroniser; stage 1 is read only by stage 2
   logic [PIN_N-1:0] sync1_ff, sync2_ff, sync3_ff;
   logic [PIN_N-1:0] pin_q_ff, nxt_pin_q; // debounced pin level
   // bus handshake state
   logic aw_ff, nxt_aw; // write address held
   logic w_ff, nxt_w; // write data held
   logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   // ready outputs kept in their own flops so no inverter sits between flop and port
   logic awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   // pad driver state
   logic [PIN_N-1:0] pout_ff, nxt_pout, poe_ff, nxt_poe, pull_ff, nxt_pull, fin_ff, nxt_fin;
   logic do_write; // both write halves held and response slot free
   logic [PIN_N-1:0] rd_lvl; // level_bits as software reads them

   // maps a byte address to a half-register select, one-hot over six words
   // the word index sits above the lane bits; an address off a word boundary maps nowhere
   function automatic logic [5:0] decode(input logic [ADDR_W-1:0] a);
      logic [5:0] s;
      s = 6'h00;
      if (a[LANE_W-1:0] == '0) begin
         case (a[ADDR_W-1:LANE_W])
            OFS_MODE_LO: s = 6'h01;
            OFS_DIR_LO: s = 6'h02;
            OFS_LVL_LO: s = 6'h04;
            OFS_MODE_HI: s = 6'h08;
            OFS_DIR_HI: s = 6'h10;
            OFS_LVL_HI: s = 6'h20;
            default: s = 6'h00;
         endcase
      end
      return s;
   endfunction

   // applies byte strobes to one 16-bit half, data in the low lanes of the word
   function automatic logic [HALF_W-1:0] merge(input logic [HALF_W-1:0] old, input logic [31:0] d,
                                              input logic [3:0] st);
      logic [HALF_W-1:0] r;
      r = old;
      if (st[0]) begin
         r[7:0] = d[7:0];
      end
      if (st[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // an output pin reads back its stored bit, so a loaded pad cannot corrupt what software sees
   // input pins show the pin level, output pins show the stored bit
   always_comb begin
      for (int i = 0; i < PIN_N; i++) begin
         rd_lvl[i] = (dir_ff[i]) ? pin_q_ff[i] : lvl_ff[i];
      end
   end

   // accept a change only once stages 2 and 3 agree, filtering one-cycle glitches
   always_comb begin
      for (int i = 0; i < PIN_N; i++) begin
         nxt_pin_q[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : pin_q_ff[i];
      end
   end

   // synchroniser chain; no reset needed, the level settles in four cycles
   always_ff @(posedge aclk) begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_q_ff <= nxt_pin_q;
   end

   // commit only with both halves held and no response still waiting for bready
   assign do_write = aw_ff && w_ff && !bvalid_ff;

   // bus next-state: address and data taken in either order, response after both
   always_comb begin
      nxt_aw = aw_ff;
      nxt_w = w_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      if (s_axi_awvalid && !aw_ff) begin // take write address
         nxt_aw = 1'b1;
         nxt_awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ff) begin // take write data
         nxt_w = 1'b1;
         nxt_wdata = s_axi_wdata;
         nxt_wstrb = s_axi_wstrb;
      end
      // a pending response holds the commit back, so bresp is never overwritten
      if (do_write) begin // commit and answer
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = (decode(awaddr_ff) != 6'h00) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
      // read data is captured when the address is taken; later pin changes do not alter it
      if (s_axi_arvalid && !rvalid_ff) begin // take read, answer next cycle
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         nxt_rdata = 32'h0000_0000; // upper half always reads zero
         case (decode(s_axi_araddr))
            6'h01: nxt_rdata[HALF_W-1:0] = mode_ff[HALF_W-1:0];
            6'h02: nxt_rdata[HALF_W-1:0] = dir_ff[HALF_W-1:0];
            6'h04: nxt_rdata[HALF_W-1:0] = rd_lvl[HALF_W-1:0];
            6'h08: nxt_rdata[HALF_W-1:0] = mode_ff[PIN_N-1:HALF_W];
            6'h10: nxt_rdata[HALF_W-1:0] = dir_ff[PIN_N-1:HALF_W];
            6'h20: nxt_rdata[HALF_W-1:0] = rd_lvl[PIN_N-1:HALF_W];
            default: nxt_rresp = RESP_SLVERR; // unmapped word
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
      // ready is the inverse of the held flag one edge ahead
      nxt_awready = !nxt_aw;
      nxt_wready = !nxt_w;
      nxt_arready = !nxt_rvalid; // one read at a time
   end

   // bus state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= '0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         arready_ff <= 1'b1;
      end else begin
         aw_ff <= nxt_aw;
         w_ff <= nxt_w;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         arready_ff <= nxt_arready;
      end
   end

   // configuration next-state; each pin owns one mode and one direction bit
   always_comb begin
      logic [5:0] sel;
      sel = decode(awaddr_ff);
      nxt_mode = mode_ff;
      nxt_dir = dir_ff;
      nxt_lvl = lvl_ff;
      if (do_write) begin
         if (sel[0]) nxt_mode[HALF_W-1:0] = merge(mode_ff[HALF_W-1:0], wdata_ff, wstrb_ff);
         if (sel[3]) nxt_mode[PIN_N-1:HALF_W] = merge(mode_ff[PIN_N-1:HALF_W], wdata_ff, wstrb_ff);
         if (sel[1]) nxt_dir[HALF_W-1:0] = merge(dir_ff[HALF_W-1:0], wdata_ff, wstrb_ff);
         // bit 15 of the upper word lands on pin 31, bit 0 on pin 16
         if (sel[4]) nxt_dir[PIN_N-1:HALF_W] = merge(dir_ff[PIN_N-1:HALF_W], wdata_ff, wstrb_ff);
         // stored even on input pins so it drives once the pin turns output
         if (sel[2]) nxt_lvl[HALF_W-1:0] = merge(lvl_ff[HALF_W-1:0], wdata_ff, wstrb_ff);
         if (sel[5]) nxt_lvl[PIN_N-1:HALF_W] = merge(lvl_ff[PIN_N-1:HALF_W], wdata_ff, wstrb_ff);
      end
   end

   // mode and direction registers with documented reset values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= {RST_MODE, RST_MODE};
         dir_ff <= {RST_DIR_HI, RST_DIR_LO};
      end else begin
         mode_ff <= nxt_mode;
         dir_ff <= nxt_dir;
      end
   end

   // a write made before the pin turns output decides its first driven level
   // level bits are left out of reset on purpose; their content is undefined
   always_ff @(posedge aclk) begin
      lvl_ff <= nxt_lvl;
   end

   // per-pin pad multiplexer from {mode, direction}
   // open-drain use works by software toggling direction with the level bit held low
   always_comb begin
      for (int i = 0; i < PIN_N; i++) begin
         nxt_fin[i] = pin_q_ff[i];
         case (pin_fn_t'({mode_ff[i], dir_ff[i]}))
            // the normal function sees the pad only while it owns the pin
            FN_NORMAL: begin // normal function owns the pad
               nxt_pout[i] = func_out[i];
               nxt_poe[i] = func_oe[i];
               nxt_pull[i] = 1'b0;
            end
            FN_IN_PULL: begin // port input, pull on
               nxt_pout[i] = 1'b0;
               nxt_poe[i] = 1'b0;
               nxt_pull[i] = 1'b1;
               nxt_fin[i] = 1'b0;
            end
            FN_OUT: begin // drive the stored bit as is
               nxt_pout[i] = lvl_ff[i];
               nxt_poe[i] = 1'b1;
               nxt_pull[i] = 1'b0;
               nxt_fin[i] = 1'b0;
            end
            default: begin // port input, no pull
               nxt_pout[i] = 1'b0;
               nxt_poe[i] = 1'b0;
               nxt_pull[i] = 1'b0;
               nxt_fin[i] = 1'b0;
            end
         endcase
      end
   end

   // pad outputs registered; reset leaves every pin undriven
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pout_ff <= '0;
         poe_ff <= '0;
         pull_ff <= '0;
         fin_ff <= '0;
      end else begin
         pout_ff <= nxt_pout;
         poe_ff <= nxt_poe;
         pull_ff <= nxt_pull;
         fin_ff <= nxt_fin;
      end
   end

   // every port comes straight from a flop
   assign pin_out = pout_ff;
   assign pin_oe = poe_ff;
   assign pin_pull_en = pull_ff;
   assign func_in = fin_ff;
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
endmodule // programmable_io_port

//--- pad_model.sv
// pad model: resolves each pin from port drive, an outside driver and the pull
// assumes pulls pull up; an undriven unpulled pin shows the inverse of its last level
`timescale 1ns/10ps
module pad_model (
   input wire logic clk, // sampling clock
   input wire logic [31:0] drv_out, // port levels
   input wire logic [31:0] drv_oe, // port enables
   input wire logic [31:0] pull_en, // pull enables
   input wire logic [31:0] ext_val, // outside levels
   input wire logic [31:0] ext_oe, // outside enables
   output logic [31:0] pad // pin levels
);
   logic [31:0] last_ff = '0; // level at the previous edge
   // a released open-drain pin floats, so a stale level must not pass for a driven one
   always_comb begin
      pad = (drv_oe & drv_out) | (~drv_oe & ext_oe & ext_val) | (~drv_oe & ~ext_oe & (pull_en | ~last_ff));
   end
   always_ff @(posedge clk) begin
      last_ff <= pad;
   end
endmodule // pad_model

//--- programmable_io_port_chk.sv
// checker for the pin port: reset state, pin drive sanity, bus answers
// sees only top ports; idle means settled after reset and before any write
`timescale 1ns/10ps
module programmable_io_port_chk
   import pio_pkg::*;
(
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, active low
   input wire logic [pio_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // write response valid
   input wire logic s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic s_axi_rvalid, // read valid
   input wire logic [pio_pkg::PIN_N-1:0] pin_oe, // pad enables
   input wire logic [pio_pkg::PIN_N-1:0] pin_pull_en, // pull enables
   input wire logic [pio_pkg::PIN_N-1:0] func_in // level to normal function
);
   logic [1:0] up_ff, nxt_up; // edges since reset, saturating
   logic seen_ff, nxt_seen; // a write was taken since reset
   logic idle; // reset configuration should be visible
   localparam logic [ADDR_W-1:0] LVL_HI_ADDR = {OFS_LVL_HI, {LANE_W{1'b0}}}; // byte address of pin_level_high
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // outputs follow config from the first edge, so three leaves margin
   always_comb begin
      nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
      nxt_seen = seen_ff | (s_axi_awvalid & s_axi_awready);
      idle = (up_ff == 2'h3) && !seen_ff;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         up_ff <= 2'h0;
         seen_ff <= 1'b0;
      end else begin
         up_ff <= nxt_up;
         seen_ff <= nxt_seen;
      end
   end
   rst_hi_dir_a: assert property (idle |-> pin_pull_en[31:16] == 16'hFFFF)
      else $error("upper pins not pulled inputs after reset");
   rst_lo_dir_a: assert property (idle |-> pin_pull_en[15:0] == 16'hFC0F)
      else $error("lower pins wrong after reset");
   rst_in_oe_a: assert property (idle |-> (pin_oe & 32'hFFFFFC0F) == 32'h0)
      else $error("input pin driven after reset");
   no_pull_drive_a: assert property ((pin_oe & pin_pull_en) == 32'h0)
      else $error("pin driven and pulled at once");
   port_func_off_a: assert property ((pin_pull_en & $past(pin_pull_en, 2) & func_in) == 32'h0)
      else $error("port pin seen by normal function");
   wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == LVL_HI_ADDR
      |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == RESP_OKAY)) else $error("level write not answered okay");
   rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   cover property (idle);
   cover property (s_axi_bvalid);
   cover property (s_axi_rvalid);
endmodule // programmable_io_port_chk
bind programmable_io_port programmable_io_port_chk programmable_io_port_chk_i (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .pin_oe, .pin_pull_en, .func_in);

//--- programmable_io_port_bench.sv
// bench for the pin port: axi4-lite register tasks and pin checks
// assumes the pad model pulls undriven pins up only where the pull is enabled
`timescale 1ns/10ps
module programmable_io_port_bench;
   import pio_pkg::*;
   logic aclk = 1'b0; // 100 mhz clock
   logic aresetn = 1'b0; // reset, active low
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr; // byte addresses
   logic [31:0] s_axi_wdata, s_axi_rdata; // data
   logic [3:0] s_axi_wstrb; // strobes
   logic [1:0] s_axi_bresp, s_axi_rresp; // responses
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready; // write side
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready; // read side
   logic [31:0] pin_in, pin_out, pin_oe, pin_pull_en, func_out, func_oe, func_in, ext_val, ext_oe; // pins
   logic [31:0] d; // last read data
   logic [1:0] r; // last response
   int fail_count = 0; // mismatches
   int tests_run = 0; // comparisons
   initial begin
      forever #5 aclk = ~aclk;
   end
   programmable_io_port programmable_io_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pin_in, .pin_out, .pin_oe, .pin_pull_en, .func_out, .func_oe, .func_in);
   pad_model pad_model_i (.clk(aclk), .drv_out(pin_out), .drv_oe(pin_oe), .pull_en(pin_pull_en), .ext_val,
      .ext_oe, .pad(pin_in));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // leading edge keeps a handshake from being raised in the step that lowered it
   task automatic wr(input logic [IDX_W-1:0] a, input logic [15:0] v);
      @(posedge aclk);
      s_axi_awaddr <= {a, {LANE_W{1'b0}}}; // byte address is four times the word index
      s_axi_wdata <= {16'h0000, v};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      repeat (8) @(posedge aclk); // pins and synchronisers settle
   endtask
   task automatic rd(input logic [IDX_W-1:0] a);
      @(posedge aclk);
      s_axi_araddr <= {a, {LANE_W{1'b0}}}; // byte address is four times the word index
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rc(input logic [IDX_W-1:0] a, input logic [15:0] e);
      rd(a);
      chk(d, {16'h0000, e});
      chk({30'h0, r}, {30'h0, RESP_OKAY}); // mapped word answers okay
   endtask
   task automatic end_sim;
      $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog: a hung handshake ends the run as a failure
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      end_sim;
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      func_out = 32'hAAAAAAAA;
      func_oe = 32'hFFFFFFFF; // normal function always tries to drive
      ext_val = 32'h0000000A;
      ext_oe = 32'h0000000F;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rc(OFS_MODE_LO, 16'h0000);
      rc(OFS_MODE_HI, 16'h0000);
      rc(OFS_DIR_LO, 16'hFC0F);
      rc(OFS_DIR_HI, 16'hFFFF);
      chk(pin_pull_en, 32'hFFFFFC0F);
      chk(pin_oe, 32'h000003F0);
      chk(pin_out & 32'h000003F0, 32'h000002A0);
      chk(func_in, 32'h000002A0);
      wr(OFS_LVL_LO, 16'h0000);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rc(OFS_LVL_LO, 16'hFC0A);
      wr(OFS_MODE_LO, 16'h000F);
      chk(pin_pull_en & 32'h0000000F, 32'h0);
      rc(OFS_LVL_LO, 16'hFC0A);
      wr(OFS_LVL_HI, 16'h8001);
      wr(OFS_MODE_HI, 16'hFFFF);
      wr(OFS_DIR_HI, 16'h0000);
      chk(pin_oe, 32'hFFFF03F0);
      chk({16'h0000, pin_out[31:16]}, 32'h00008001);
      rc(OFS_LVL_HI, 16'h8001);
      for (int fn = 0; fn < 4; fn++) begin
         wr(OFS_MODE_HI, fn[1] ? 16'hFFFF : 16'hFFEF);
         wr(OFS_DIR_HI, fn[0] ? 16'h0010 : 16'h0000);
         chk({30'h0, pin_oe[20], pin_pull_en[20]}, {30'h0, fn == 0 || fn == 2, fn == 1});
      end
      wr(OFS_LVL_HI, 16'h8000);
      for (int k = 1; k >= 0; k--) begin
         wr(OFS_DIR_HI, {15'h0000, k[0]});
         chk({31'h0, pin_oe[16]}, {31'h0, ~k[0]});
      end
      chk({31'h0, pin_out[16]}, 32'h0);
      wr(8'h7C, 16'h1234);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h7C);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rc(OFS_DIR_HI, 16'hFFFF);
      rc(OFS_DIR_LO, 16'hFC0F);
      end_sim;
   end
endmodule // programmable_io_port_bench
